// [rtl/tcms_pkg.sv]
// Purpose: Shared constants for the TDM clock master select block.
// Assumes: System clock of 200 MHz on clock_i.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package tcms_pkg;
    // System clock.
    localparam int unsigned SYS_CLK_HZ = 200000000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    // Bus data clock target and local rate generator divide factor.
    localparam int unsigned BIT_CLOCK_HZ = 2048000;
    localparam int unsigned LRG_DIV = (SYS_CLK_HZ + BIT_CLOCK_HZ / 2) / BIT_CLOCK_HZ;
    localparam int unsigned LRG_HALF = LRG_DIV / 2;
    // Frame layout.
    localparam int unsigned SLOTS_PER_FRAME = 32;
    localparam int unsigned BITS_PER_SLOT = 8;
    localparam int unsigned FRAME_DIV = SLOTS_PER_FRAME * BITS_PER_SLOT;
    localparam int unsigned FRAME_W = 8;
    localparam int unsigned SLOT_W = 5;
    localparam int unsigned BIT_W = 3;
    localparam int unsigned SLOTS_PER_LINE = 3;
    localparam int unsigned MAX_LINES = 10;
    localparam int unsigned DCHAN_DATA_BITS = 2;
    localparam logic [FRAME_W-1:0] FRAME_LAST = 8'hFF;
    localparam logic [FRAME_W-1:0] FRAME_FIRST = 8'h00;
    // Channel kinds within one line's group of three slots.
    localparam logic [1:0] CHAN_B1 = 2'h0;
    localparam logic [1:0] CHAN_B2 = 2'h1;
    localparam logic [1:0] CHAN_D = 2'h2;
    localparam logic [1:0] CHAN_NONE = 2'h3;
    // Switch deadlines after a line interrupt.
    localparam int unsigned ACT_SWITCH_NS = 750000;
    localparam int unsigned DEACT_SWITCH_NS = 72800;
    localparam int unsigned ACT_SWITCH_CYC = ACT_SWITCH_NS / CLK_PERIOD_NS;
    localparam int unsigned DEACT_SWITCH_CYC = DEACT_SWITCH_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 18;
    // Clock switch sequencer states.
    typedef enum logic [2:0]
    {
        SW_RUN = 3'b001,
        SW_PARK = 3'b010,
        SW_ALIGN = 3'b100
    } tcms_sw_type;
endpackage : tcms_pkg

// [rtl/tcms_rate_gen.sv]
// Purpose: Local rate generator, a square wave near the bus data clock rate.
// Assumes: Runs on the system clock; HALF_CYC is at least one.
// Notes: Free-running; only its pseudo timing is used while no line is up.
`timescale 1ns/1ps
module tcms_rate_gen
#(
    parameter int unsigned HALF_CYC = tcms_pkg::LRG_HALF
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    output logic rate_clk_o
);
    import tcms_pkg::*;

    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic clk_q;
    logic clk_d;

    // Toggle the output every HALF_CYC system clocks.
    always_comb
    begin
        cnt_d = cnt_q + CW'(1);
        clk_d = clk_q;
        if (cnt_q == LAST)
        begin
            cnt_d = '0;
            clk_d = ~clk_q;
        end
    end

    // Register the divider state.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign rate_clk_o = clk_q;
endmodule : tcms_rate_gen

// [rtl/tcms_clock_master.sv]
// Purpose: Select the bus clock master, drive the bus data clock and frame sync.
// Assumes: Recovered clocks arrive as synchronous inputs, far slower than clock_i.
// Notes: Source 0 is the local rate generator, source k is line k-1.
`timescale 1ns/1ps
module tcms_clock_master
#(
    parameter int unsigned LINES = tcms_pkg::MAX_LINES,
    parameter int unsigned ACT_LIMIT = tcms_pkg::ACT_SWITCH_CYC,
    parameter int unsigned DEACT_LIMIT = tcms_pkg::DEACT_SWITCH_CYC
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [LINES-1:0] recovered_net_clock_i,
    input wire logic [$clog2(LINES+1)-1:0] master_select_i,
    input wire logic activation_irq_i,
    input wire logic deactivation_irq_i,
    input wire logic miss_clear_i,
    output logic bit_clock_line_o,
    output logic frame_sync_pulse_o,
    output logic [$clog2(LINES+1)-1:0] active_master_o,
    output logic switch_busy_o,
    output logic network_timing_o,
    output logic deadline_miss_o,
    output logic [tcms_pkg::SLOT_W-1:0] slot_index_o,
    output logic [tcms_pkg::BIT_W-1:0] bit_index_o,
    output logic [3:0] line_index_o,
    output logic [1:0] channel_kind_o,
    output logic data_bit_valid_o
);
    import tcms_pkg::*;

    localparam int unsigned SW = $clog2(LINES + 1);
    localparam logic [SW-1:0] SEL_LOCAL = '0;
    localparam logic [TIMER_W-1:0] ACT_LOAD = TIMER_W'(ACT_LIMIT);
    localparam logic [TIMER_W-1:0] DEACT_LOAD = TIMER_W'(DEACT_LIMIT);

    logic rate_clk;
    logic [LINES:0] src_q;
    logic [LINES:0] src_d;
    logic cur_src;
    logic new_src;
    tcms_sw_type sw_q;
    tcms_sw_type sw_d;
    logic [SW-1:0] cur_q;
    logic [SW-1:0] cur_d;
    logic [SW-1:0] tgt_q;
    logic [SW-1:0] tgt_d;
    logic dcl_q;
    logic dcl_d;
    logic [FRAME_W-1:0] cnt_q;
    logic [FRAME_W-1:0] cnt_d;
    logic fs_q;
    logic fs_d;
    logic [TIMER_W-1:0] tmr_q;
    logic [TIMER_W-1:0] tmr_d;
    logic tmr_run_q;
    logic tmr_run_d;
    logic miss_q;
    logic miss_d;
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] slot_d;
    logic [BIT_W-1:0] bit_q;
    logic [BIT_W-1:0] bit_d;
    logic [3:0] line_q;
    logic [3:0] line_d;
    logic [1:0] kind_q;
    logic [1:0] kind_d;
    logic valid_q;
    logic valid_d;
    logic dcl_rise;

    // Local rate generator for pseudo timing while no line is active.
    tcms_rate_gen #(
        .HALF_CYC(LRG_HALF)
    ) u_rate_gen (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .rate_clk_o(rate_clk)
    );

    // Sample every candidate master clock; entry 0 is the local generator.
    assign src_d[0] = rate_clk;
    generate
        for (genvar g = 0; g < LINES; g++)
        begin : g_src
            assign src_d[g+1] = recovered_net_clock_i[g];
        end
    endgenerate

    assign cur_src = src_q[cur_q];
    assign new_src = src_q[tgt_q];

    // Switch sequencer: park low on the old source, resume when the new is low.
    always_comb
    begin
        sw_d = sw_q;
        cur_d = cur_q;
        tgt_d = tgt_q;
        dcl_d = dcl_q;
        case (sw_q)
            SW_RUN:
            begin
                dcl_d = cur_src;
                if (master_select_i != cur_q && master_select_i <= SW'(LINES))
                begin
                    tgt_d = master_select_i;
                    sw_d = SW_PARK;
                end
            end
            SW_PARK:
            begin
                dcl_d = cur_src;
                if (!cur_src)
                begin
                    sw_d = SW_ALIGN;
                end
            end
            SW_ALIGN:
            begin
                dcl_d = 1'b0;
                if (!new_src)
                begin
                    cur_d = tgt_q;
                    sw_d = SW_RUN;
                end
            end
            default:
            begin
                sw_d = SW_RUN;
                dcl_d = 1'b0;
            end
        endcase
    end

    assign dcl_rise = dcl_d & ~dcl_q;

    // Divide by 256 on data clock rising edges; sync spans one full period.
    always_comb
    begin
        cnt_d = cnt_q;
        fs_d = fs_q;
        if (dcl_rise)
        begin
            cnt_d = cnt_q + FRAME_W'(1);
            fs_d = (cnt_q == FRAME_LAST);
        end
    end

    // Frame position decode: slot, bit, line and channel kind.
    always_comb
    begin
        slot_d = cnt_q[FRAME_W-1:BIT_W];
        bit_d = cnt_q[BIT_W-1:0];
        line_d = 4'(slot_d / SLOT_W'(SLOTS_PER_LINE));
        kind_d = 2'(slot_d % SLOT_W'(SLOTS_PER_LINE));
        valid_d = 1'b1;
        if (line_d >= 4'(MAX_LINES))
        begin
            kind_d = CHAN_NONE;
            valid_d = 1'b0;
        end
        else if (kind_d == CHAN_D && bit_d >= BIT_W'(DCHAN_DATA_BITS))
        begin
            valid_d = 1'b0;
        end
        if (cur_q == SEL_LOCAL || sw_q != SW_RUN)
        begin
            valid_d = 1'b0;
        end
    end

    // Deadline watch: an irq arms the limit, a finished switch disarms it.
    always_comb
    begin
        tmr_d = tmr_q;
        tmr_run_d = tmr_run_q;
        miss_d = miss_q & ~miss_clear_i;
        if (activation_irq_i)
        begin
            tmr_d = ACT_LOAD;
            tmr_run_d = 1'b1;
        end
        else if (deactivation_irq_i)
        begin
            tmr_d = DEACT_LOAD;
            tmr_run_d = 1'b1;
        end
        else if (tmr_run_q)
        begin
            if (sw_q == SW_ALIGN && sw_d == SW_RUN)
            begin
                tmr_run_d = 1'b0;
            end
            else if (tmr_q == '0)
            begin
                tmr_run_d = 1'b0;
                miss_d = 1'b1;
            end
            else
            begin
                tmr_d = tmr_q - TIMER_W'(1);
            end
        end
    end

    // Register all state.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            src_q <= '0;
            sw_q <= SW_RUN;
            cur_q <= SEL_LOCAL;
            tgt_q <= SEL_LOCAL;
            dcl_q <= 1'b0;
            cnt_q <= FRAME_FIRST;
            fs_q <= 1'b0;
            tmr_q <= '0;
            tmr_run_q <= 1'b0;
            miss_q <= 1'b0;
            slot_q <= '0;
            bit_q <= '0;
            line_q <= '0;
            kind_q <= CHAN_B1;
            valid_q <= 1'b0;
        end
        else
        begin
            src_q <= src_d;
            sw_q <= sw_d;
            cur_q <= cur_d;
            tgt_q <= tgt_d;
            dcl_q <= dcl_d;
            cnt_q <= cnt_d;
            fs_q <= fs_d;
            tmr_q <= tmr_d;
            tmr_run_q <= tmr_run_d;
            miss_q <= miss_d;
            slot_q <= slot_d;
            bit_q <= bit_d;
            line_q <= line_d;
            kind_q <= kind_d;
            valid_q <= valid_d;
        end
    end

    // Outputs; bus clock and sync are driven here only, never by the controller.
    assign bit_clock_line_o = dcl_q;
    assign frame_sync_pulse_o = fs_q;
    assign active_master_o = cur_q;
    assign switch_busy_o = (sw_q != SW_RUN);
    assign network_timing_o = (cur_q != SEL_LOCAL) && (sw_q == SW_RUN);
    assign deadline_miss_o = miss_q;
    assign slot_index_o = slot_q;
    assign bit_index_o = bit_q;
    assign line_index_o = line_q;
    assign channel_kind_o = kind_q;
    assign data_bit_valid_o = valid_q;
endmodule : tcms_clock_master

// [tb/tcms_sva.sv]
// Purpose: Checker for the clock master select block.
// Assumes: Bound to tcms_clock_master.
// Notes: Watches design outputs and the master_select_i input.
`timescale 1ns/1ps
module tcms_sva
import tcms_pkg::*;
#(
    parameter int unsigned LINES = 10
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [$clog2(LINES+1)-1:0] master_select_i,
    input wire logic bit_clock_line_o,
    input wire logic frame_sync_pulse_o,
    input wire logic [$clog2(LINES+1)-1:0] active_master_o,
    input wire logic switch_busy_o,
    input wire logic network_timing_o,
    input wire logic [tcms_pkg::SLOT_W-1:0] slot_index_o,
    input wire logic [tcms_pkg::BIT_W-1:0] bit_index_o,
    input wire logic [3:0] line_index_o,
    input wire logic [1:0] channel_kind_o,
    input wire logic data_bit_valid_o
);
    logic [8:0] rises_q;
    logic seen_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Counts data clock rises from one frame sync to the next.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            rises_q <= 9'h000;
            seen_q <= 1'b0;
        end
        else if ($rose(bit_clock_line_o))
        begin
            rises_q <= frame_sync_pulse_o ? 9'h001 : rises_q + 9'h001;
            seen_q <= seen_q | frame_sync_pulse_o;
        end
    end
    chk_frame_len: assert property ($rose(frame_sync_pulse_o) && seen_q |-> rises_q == 9'h100)
        else $error("frame length wrong");
    chk_sync_one_clock: assert property ($fell(frame_sync_pulse_o) |-> $rose(bit_clock_line_o))
        else $error("sync width wrong");
    chk_no_runt: assert property ($rose(bit_clock_line_o) |-> bit_clock_line_o [*8])
        else $error("runt clock pulse");
    chk_switch_starts: assert property (!switch_busy_o && master_select_i <= LINES
        && master_select_i != active_master_o |=> switch_busy_o)
        else $error("switch not started");
    chk_commit_on_switch: assert property ($changed(active_master_o) |-> $past(switch_busy_o))
        else $error("master changed idle");
    chk_net_timing: assert property (network_timing_o |-> active_master_o != 0 && !switch_busy_o)
        else $error("network timing wrong");
    chk_slot_map: assert property (line_index_o == slot_index_o / 3 && channel_kind_o ==
        (slot_index_o >= 30 ? CHAN_NONE : 2'(slot_index_o % 3)))
        else $error("slot map wrong");
    chk_valid_bits: assert property (data_bit_valid_o |-> channel_kind_o != CHAN_NONE
        && (channel_kind_o != CHAN_D || bit_index_o < 2))
        else $error("valid bit wrong");
    chk_valid_on_line: assert property ($past(network_timing_o) && channel_kind_o != CHAN_NONE
        && (channel_kind_o != CHAN_D || bit_index_o < 2) |-> data_bit_valid_o)
        else $error("line bit not valid");
    cov_switch: cover property ($rose(switch_busy_o));
    cov_sync: cover property ($rose(frame_sync_pulse_o) && seen_q);
    cov_valid: cover property ($rose(data_bit_valid_o));
endmodule : tcms_sva
bind tcms_clock_master tcms_sva #(.LINES(LINES)) chk (.*);

// [tb/tcms_line_model.sv]
// Purpose: Bank of line transceivers giving recovered clocks.
// Assumes: Every line selects the 2.048 MHz clock with output enabled.
// Notes: Lines are bus slaves and drive no data clock or sync.
`timescale 1ns/1ps
module tcms_line_model
#(
    parameter int unsigned LINES = 10,
    parameter int unsigned HALF = 49,
    parameter int unsigned DCL_GAP = 400,
    parameter int unsigned FS_GAP = 30000
)
(
    input wire logic clock_i,
    input wire logic [LINES-1:0] active_i,
    input wire logic bit_clock_i,
    input wire logic frame_sync_i,
    output logic [LINES-1:0] clock_o
);
    int cnt = 0;
    logic ph = 1'b0;
    int dcl_age = DCL_GAP;
    int fs_age = FS_GAP;
    logic dcl_prev = 1'b0;
    logic tx_frame_sync_in;
    logic rx_frame_sync_in;
    logic dchan_request;
    logic timing_ok;
    // Shared phase toggles every HALF cycles, free of any tie to the frame sync phase.
    always @(posedge clock_i)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            ph <= ~ph;
    end
    // Both sync inputs of every line hang on the one common frame sync.
    assign tx_frame_sync_in = frame_sync_i;
    assign rx_frame_sync_in = frame_sync_i;
    // Lines are point-to-point, so contention is off and the request pin is tied low.
    assign dchan_request = 1'b0;
    // Ages of the last data clock edge and the last frame sync seen on the bus.
    always @(posedge clock_i)
    begin
        dcl_prev <= bit_clock_i;
        dcl_age <= (bit_clock_i != dcl_prev) ? 0 : dcl_age + 1;
        fs_age <= (tx_frame_sync_in && rx_frame_sync_in) ? 0 : fs_age + 1;
    end
    // Bus timing counts as present while both clock and sync were seen lately.
    assign timing_ok = (dcl_age < DCL_GAP) && (fs_age < FS_GAP) && !dchan_request;
    // Idle lines, or lines without bus timing, give no clock and stand low.
    assign clock_o = active_i & {LINES{ph & timing_ok}};
endmodule : tcms_line_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the clock master select block.
// Assumes: Line model runs at the local generator rate.
// Notes: Deadline limits are shortened.
`timescale 1ns/1ps
module tb;
    import tcms_pkg::*;
    localparam longint FRAME_NS = 256 * 98 * 5;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [9:0] up = 10'h000;
    logic [9:0] rclk;
    logic [3:0] sel = 4'h0;
    logic act = 1'b0;
    logic deact = 1'b0;
    logic clr = 1'b0;
    logic bit_clock_line, fs, busy, net, miss, valid;
    logic [3:0] master, line;
    logic [4:0] slot;
    logic [2:0] bitx;
    logic [1:0] kind;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    tcms_clock_master #(.LINES(10), .ACT_LIMIT(300), .DEACT_LIMIT(150)) dut
    (
        .clock_i(clock_i), .resetn_i(resetn_i), .recovered_net_clock_i(rclk),
        .master_select_i(sel), .activation_irq_i(act), .deactivation_irq_i(deact),
        .miss_clear_i(clr), .bit_clock_line_o(bit_clock_line), .frame_sync_pulse_o(fs),
        .active_master_o(master), .switch_busy_o(busy), .network_timing_o(net),
        .deadline_miss_o(miss), .slot_index_o(slot), .bit_index_o(bitx),
        .line_index_o(line), .channel_kind_o(kind), .data_bit_valid_o(valid)
    );
    tcms_line_model #(.LINES(10), .HALF(49)) u_lines
    (
        .clock_i(clock_i), .active_i(up), .bit_clock_i(bit_clock_line), .frame_sync_i(fs), .clock_o(rclk)
    );
    always #2.5 clock_i = ~clock_i;
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : compare
    task automatic pulse(ref logic s);
        @(negedge clock_i) s = 1'b1;
        @(negedge clock_i) s = 1'b0;
    endtask : pulse
    task automatic switch_to(input logic [3:0] v);
        @(negedge clock_i) sel = v;
        repeat (2) @(negedge clock_i);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(negedge clock_i);
    endtask : switch_to
    task automatic frame();
        longint t;
        @(posedge fs);
        t = $time;
        @(posedge fs);
        compare(32'($time - t), 32'(FRAME_NS));
    endtask : frame
    task automatic t_local();
        compare({master, busy, miss, net}, 0);
        frame();
        compare(valid, 0);
        $display("test local done");
    endtask : t_local
    task automatic t_activate();
        @(negedge clock_i) up[2] = 1'b1;
        pulse(act);
        switch_to(4'h3);
        compare({master, net, miss}, 6'h0E);
        frame();
        // Three data clocks after the sync the frame sits in slot 0, bit 3, a live bearer bit.
        repeat (300) @(negedge clock_i);
        compare({line, kind, slot, bitx, valid}, 15'h0007);
        $display("test activate done");
    endtask : t_activate
    task automatic t_deact();
        @(negedge clock_i) up[5] = 1'b1;
        pulse(deact);
        switch_to(4'h6);
        compare({master, miss}, 5'h0C);
        pulse(deact);
        repeat (160) @(negedge clock_i);
        compare(miss, 1);
        pulse(clr);
        compare(miss, 0);
        switch_to(4'h0);
        compare({master, net}, 0);
        @(negedge clock_i) up = 10'h000;
        $display("test deactivate done");
    endtask : t_deact
    task automatic t_illegal();
        @(negedge clock_i) sel = 4'hB;
        repeat (3) @(negedge clock_i);
        compare({busy, master}, 0);
        sel = 4'h0;
        $display("test illegal done");
    endtask : t_illegal
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // Cuts a hang short.
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 120000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    // Main sequence.
    initial
    begin
        repeat (16) @(negedge clock_i);
        resetn_i = 1'b1;
        t_local();
        t_activate();
        t_deact();
        t_illegal();
        tally_and_finish();
    end
endmodule : tb
